// *** hw/emap_addr_calc.sv ***
// Logical to physical address mapping and bank select decode.
// Assumes the caller registers the results; purely combinational.
`timescale 1ns/10ps
module emap_addr_calc (
   input wire logic [23:0] laddr_in,
   input wire logic bus8_in,
   input wire logic fmt24_in,
   input wire logic xfer24_in,
   input wire logic [1:0] sub_in,
   output logic [21:0] paddr_out,
   output logic [3:0] bank_select_n_out
);
   import emap_pkg::*;

   logic s24;
   logic [1:0] shift;
   logic [25:0] scaled;
   logic [21:0] offs;
   logic [21:0] rel;

   // -------------------------------------------------------------------
   // Multipliers are powers of two, so the product is a shift
   // -------------------------------------------------------------------
   always_comb begin
      s24 = emap_eff24(fmt24_in, xfer24_in);
      shift = emap_size_shift(bus8_in, s24) + {1'b0, fmt24_in & ~xfer24_in};
      scaled = {2'h0, laddr_in} << shift;
      // Byte lane 0 of a 24-bit word on a byte bus stays unused
      offs = (s24 && bus8_in) ? 22'(sub_in) + 22'h00_0001 : 22'(sub_in);
      paddr_out = scaled[21:0] + offs;
      rel = paddr_out - EMAP_BANK0_BASE;
      bank_select_n_out = 4'hf;
      // Below bank 0 nothing external is selected
      if (paddr_out >= EMAP_BANK0_BASE) begin
         bank_select_n_out[rel[EMAP_BANK_SHIFT +: 2]] = 1'b0;
      end
   end

endmodule

// *** hw/emap_pkg.sv ***
// Constants, carriers and helpers for the external memory address mapper.
// Assumes one 50 MHz clock, a core that issues whole-word requests and
// asynchronous memories that may stretch an access with the acknowledge pin.
// Behaviour
// - Size factor from bus width and transfer size
// - Physical address is format x size x logical
// - 24-bit on 8-bit bus: skip byte, low, mid, high
// - 24-bit on 16-bit bus: low byte high half, then upper
// - 16-bit on 8-bit bus: low byte first
// - 16-bit on 16-bit bus: one unchanged access
// - Boot space uses same mapping, boot select
// - Boot loading reads from logical boot-load address
// - Keep only low 22 physical address bits
// - I/O space uses same mapping, I/O select
// - Drive a 22-bit external address bus
// - 16-bit data bus, sampled at strobe end
// - Upper data pins become flags on 8-bit bus
// - Active-low bank selects held whole access
// - Bank 0 at 0x10000, banks 1-3 follow
// - Selects follow address, idle when no access
// - Strobe only after address and select
// - Acknowledge low inserts waits in ack and both modes
// - Bus request answered with bus grant
// - Grant-hung while stalled by granted bus
// - Boot space allows writes as well as reads
// - Float address, data, selects, strobes while granted
// - 24-bit format with 16-bit transfer doubles address
// - 16-bit format with 24-bit transfer drops low byte
// - Access count per word from bus and size
package emap_pkg;

   // -------------------------------------------------------------------
   // Register map and fields
   // -------------------------------------------------------------------
   localparam logic [3:0] EMAP_CTRL_OFS = 4'h0;
   localparam logic [3:0] EMAP_STAT_OFS = 4'h4;
   localparam int EMAP_BWS_POS = 0;
   localparam int EMAP_DFS_POS = 1;
   localparam int EMAP_WMODE_POS = 2;
   localparam int EMAP_WCNT_POS = 4;
   localparam logic [7:0] EMAP_CTRL_RST = 8'h01;
   localparam logic [1:0] EMAP_WM_COUNT = 2'h0;
   localparam logic [1:0] EMAP_WM_ACK = 2'h1;
   localparam logic [1:0] EMAP_WM_BOTH = 2'h2;
   localparam logic [1:0] EMAP_WM_EITHER = 2'h3;

   // -------------------------------------------------------------------
   // Address spaces
   // -------------------------------------------------------------------
   localparam logic [1:0] EMAP_SP_MEM = 2'h0;
   localparam logic [1:0] EMAP_SP_BOOT = 2'h1;
   localparam logic [1:0] EMAP_SP_IO = 2'h2;
   localparam logic [21:0] EMAP_BANK0_BASE = 22'h01_0000;
   localparam int EMAP_BANK_SHIFT = 20;
   localparam logic [23:0] EMAP_BOOT_LOAD = 24'h08_0000;

   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_STRB, ST_GRANT} emap_state_e;

   typedef struct packed {
      logic write;
      logic xfer24;
      logic boot_load;
      logic [1:0] space;
      logic [23:0] addr;
      logic [23:0] wdata;
   } emap_req_s;

   typedef struct packed {
      logic [21:0] addr;
      logic [3:0] bank_select_n;
      logic boot_space_select_n;
      logic io_space_select_n;
      logic rd_n;
      logic wr_n;
      logic pin_oe;
   } emap_pins_s;

   typedef struct packed {
      emap_state_e st;
      emap_req_s req;
      logic pend;
      logic [1:0] sub;
      logic [3:0] wcnt;
      logic [7:0] ctrl;
      emap_pins_s pins;
      logic [15:0] dout;
      logic [15:0] doe;
      logic [23:0] racc;
      logic [23:0] rdata;
      logic done;
      logic grant;
      logic hung;
      logic [15:0] rbk;
      logic [7:0] flags;
   } emap_state_s;

   // A full transfer is 24 bits only when the memory format is 24 bits too
   function automatic logic emap_eff24(input logic fmt24, input logic xfer24);
      return fmt24 & xfer24;
   endfunction

   // Size shift doubles as index of the last part access of a word
   function automatic logic [1:0] emap_size_shift(input logic bus8, input logic s24);
      return s24 ? (bus8 ? 2'h2 : 2'h1) : {1'b0, bus8};
   endfunction

endpackage

// *** hw/emap_top.sv ***
// External memory port: address mapping, lane packing and pin sequencing.
// Assumes synchronous inputs on ref_clk_in, a core that waits on busy_out,
// and an outside master that only drives the bus while granted.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module emap_top (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   input wire logic req_valid_in,
   input wire emap_pkg::emap_req_s req_in,
   output logic busy_out,
   output logic done_out,
   output logic [23:0] rdata_out,
   output emap_pkg::emap_pins_s pins_out,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic [15:0] data_oe_out,
   input wire logic ack_in,
   input wire logic bus_request_in,
   output logic bus_grant_out,
   output logic grant_hung_out,
   input wire logic [7:0] flag_dout_in,
   input wire logic [7:0] flag_oe_in,
   output logic [7:0] upper_flag_pins_out
);
   import emap_pkg::*;

   emap_state_s q;
   emap_state_s d;
   logic [21:0] paddr;
   logic [3:0] bank_n;
   logic [1:0] sub_sel;
   logic bus8;
   logic fmt24;
   logic s24;
   logic [1:0] last_sub;
   logic [1:0] wmode;
   logic cnt_ok;
   logic wait_done;
   logic drv;
   logic [23:0] img;

   // Word lane for one part access of a write
   function automatic logic [15:0] emap_lane(input logic [23:0] w, input logic [1:0] sub,
                                              input logic b8, input logic w24);
      logic [15:0] v;
      v = w[15:0];
      if (b8) begin
         v = {8'h00, w[{sub, 3'b000} +: 8]};
      end else if (w24) begin
         v = (sub == 2'h0) ? {w[7:0], 8'h00} : w[23:8];
      end
      return v;
   endfunction

   // -------------------------------------------------------------------
   // Configuration decode
   // -------------------------------------------------------------------
   assign bus8 = ~q.ctrl[EMAP_BWS_POS];
   assign fmt24 = q.ctrl[EMAP_DFS_POS];
   assign wmode = q.ctrl[EMAP_WMODE_POS +: 2];
   assign s24 = emap_eff24(fmt24, q.req.xfer24);
   assign last_sub = emap_size_shift(bus8, s24);
   assign sub_sel = (q.st == ST_STRB) ? q.sub + 2'h1 : 2'h0;

   // Address of the part access that is about to start
   emap_addr_calc u_calc (
      .laddr_in(q.req.addr),
      .bus8_in(bus8),
      .fmt24_in(fmt24),
      .xfer24_in(q.req.xfer24),
      .sub_in(sub_sel),
      .paddr_out(paddr),
      .bank_select_n_out(bank_n)
   );

   // Write image; a 24-bit write into 16-bit format loses its low byte
   always_comb begin
      if (s24) begin
         img = q.req.wdata;
      end else if (q.req.xfer24) begin
         img = {8'h00, q.req.wdata[23:8]};
      end else begin
         img = {8'h00, q.req.wdata[15:0]};
      end
   end

   // Wait-state termination for each mode
   always_comb begin
      cnt_ok = q.wcnt >= q.ctrl[EMAP_WCNT_POS +: 4];
      case (wmode)
         EMAP_WM_ACK: wait_done = ack_in;
         EMAP_WM_BOTH: wait_done = cnt_ok & ack_in;
         EMAP_WM_EITHER: wait_done = cnt_ok | ack_in;
         default: wait_done = cnt_ok;
      endcase
   end

   // -------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------
   always_comb begin
      d = q;
      d.done = 1'b0;
      d.rbk = 16'h0000;
      drv = 1'b0;
      // Mapping must not move under a word in flight, so writes are dropped while one is pending
      if (reg_wr_in && reg_addr_in == EMAP_CTRL_OFS && !q.pend) begin
         d.ctrl = reg_wdata_in[7:0];
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            EMAP_CTRL_OFS: d.rbk = {8'h00, q.ctrl};
            EMAP_STAT_OFS: d.rbk = {12'h000, q.hung, q.grant, q.st != ST_IDLE, q.pend};
            default: d.rbk = 16'h0000;
         endcase
      end
      // One word request is held until all its part accesses are done
      if (req_valid_in && !q.pend) begin
         d.pend = 1'b1;
         d.req = req_in;
         if (req_in.boot_load) begin
            d.req.addr = req_in.addr + EMAP_BOOT_LOAD;
            d.req.space = EMAP_SP_BOOT;
         end
      end
      case (q.st)
         ST_IDLE: begin
            if (bus_request_in) begin
               d.st = ST_GRANT;
               d.grant = 1'b1;
               d.pins.pin_oe = 1'b0;
            end else if (q.pend) begin
               d.st = ST_ADDR;
               d.sub = 2'h0;
               d.racc = 24'h00_0000;
               d.pins.addr = paddr;
               d.pins.bank_select_n = (q.req.space == EMAP_SP_MEM) ? bank_n : 4'hf;
               d.pins.boot_space_select_n = q.req.space != EMAP_SP_BOOT;
               d.pins.io_space_select_n = q.req.space != EMAP_SP_IO;
               d.dout = emap_lane(img, 2'h0, bus8, s24);
            end
         end
         ST_ADDR: begin
            // Strobe follows the address by one full cycle
            d.st = ST_STRB;
            d.wcnt = 4'h0;
            d.pins.rd_n = q.req.write;
            d.pins.wr_n = ~q.req.write;
         end
         ST_STRB: begin
            d.wcnt = (q.wcnt == 4'hf) ? q.wcnt : q.wcnt + 4'h1;
            if (wait_done) begin
               d.pins.rd_n = 1'b1;
               d.pins.wr_n = 1'b1;
               // Data taken as the strobe rises
               if (!q.req.write) begin
                  if (bus8) begin
                     d.racc[{q.sub, 3'b000} +: 8] = data_in[7:0];
                  end else if (s24 && q.sub == 2'h0) begin
                     d.racc[7:0] = data_in[15:8];
                  end else if (s24) begin
                     d.racc[23:8] = data_in;
                  end else begin
                     d.racc[15:0] = data_in;
                  end
               end
               if (q.sub == last_sub) begin
                  d.st = ST_IDLE;
                  d.pend = 1'b0;
                  d.done = 1'b1;
                  d.pins.bank_select_n = 4'hf;
                  d.pins.boot_space_select_n = 1'b1;
                  d.pins.io_space_select_n = 1'b1;
                  if (s24) begin
                     d.rdata = d.racc;
                  end else if (q.req.xfer24) begin
                     d.rdata = {d.racc[15:0], 8'h00};
                  end else begin
                     d.rdata = {8'h00, d.racc[15:0]};
                  end
               end else begin
                  // Selects stay low between parts of one word
                  d.st = ST_ADDR;
                  d.sub = q.sub + 2'h1;
                  d.pins.addr = paddr;
                  if (q.req.space == EMAP_SP_MEM) begin
                     d.pins.bank_select_n = bank_n;
                  end
                  d.dout = emap_lane(img, sub_sel, bus8, s24);
               end
            end
         end
         ST_GRANT: begin
            d.hung = q.pend;
            if (!bus_request_in) begin
               d.st = ST_IDLE;
               d.grant = 1'b0;
               d.hung = 1'b0;
               d.pins.pin_oe = 1'b1;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
      // Data lanes driven only during a write while we own the bus
      drv = d.req.write && (d.st == ST_ADDR || d.st == ST_STRB);
      d.doe[7:0] = {8{drv}};
      if (bus8) begin
         d.doe[15:8] = flag_oe_in;
         d.dout[15:8] = flag_dout_in;
         d.flags = data_in[15:8];
      end else begin
         d.doe[15:8] = {8{drv}};
         d.flags = 8'h00;
      end
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         q <= '{st: ST_IDLE, ctrl: EMAP_CTRL_RST,
                pins: '{addr: 22'h00_0000, bank_select_n: 4'hf, boot_space_select_n: 1'b1,
                        io_space_select_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, pin_oe: 1'b1},
                default: '0};
      end else begin
         q <= d;
      end
   end

   // Outputs come straight from the state register
   assign reg_rdata_out = q.rbk;
   assign busy_out = q.pend;
   assign done_out = q.done;
   assign rdata_out = q.rdata;
   assign pins_out = q.pins;
   assign data_out = q.dout;
   assign data_oe_out = q.doe;
   assign bus_grant_out = q.grant;
   assign grant_hung_out = q.hung;
   assign upper_flag_pins_out = q.flags;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   // Part accesses started for the current word
   logic [2:0] n_strb;
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || q.done) begin
         n_strb <= 3'h0;
      end else if (q.st == ST_ADDR) begin
         n_strb <= n_strb + 3'h1;
      end
   end

   a_strobe_after_sel: assert property (
      ($fell(q.pins.rd_n) || $fell(q.pins.wr_n)) |->
         $stable(q.pins.addr) && $past(q.st) == ST_ADDR &&
         (q.pins.bank_select_n != 4'hf || !q.pins.boot_space_select_n || !q.pins.io_space_select_n))
      else $error("strobe asserted before address and select");

   a_grant_float: assert property (
      q.grant |-> !q.pins.pin_oe && q.doe[7:0] == 8'h00)
      else $error("pins driven while bus granted");

   a_idle_selects: assert property (
      q.st == ST_IDLE |-> q.pins.bank_select_n == 4'hf && q.pins.rd_n && q.pins.wr_n &&
         q.pins.boot_space_select_n && q.pins.io_space_select_n)
      else $error("select or strobe active while idle");

   a_hung_granted: assert property (
      q.hung |-> q.grant && q.pend)
      else $error("grant hung without grant and waiting word");

   a_grant_release: assert property (
      q.st == ST_GRANT && !bus_request_in |=> !q.grant && q.pins.pin_oe)
      else $error("grant not released after request dropped");

   a_ack_holds: assert property (
      q.st == ST_STRB && wmode == EMAP_WM_ACK && !ack_in |=> q.st == ST_STRB && !(q.pins.rd_n && q.pins.wr_n))
      else $error("access ended while acknowledge low");

   a_part_count: assert property (
      q.done |-> n_strb == {1'b0, $past(last_sub)} + 3'h1)
      else $error("wrong number of part accesses for word");

   a_select_held: assert property (
      q.st == ST_STRB && q.req.space == EMAP_SP_MEM && q.sub != last_sub && wait_done |=>
         q.pins.bank_select_n != 4'hf)
      else $error("bank select dropped between parts of a word");

   a_bank_onehot: assert property (
      q.st == ST_ADDR && q.req.space == EMAP_SP_MEM && q.pins.addr >= EMAP_BANK0_BASE |->
         $countones(~q.pins.bank_select_n) == 1)
      else $error("bank decode not one-hot");

   a_boot_select: assert property (
      !q.pins.boot_space_select_n |-> q.req.space == EMAP_SP_BOOT && q.pins.bank_select_n == 4'hf)
      else $error("boot select with wrong space");

   a_io_select: assert property (
      !q.pins.io_space_select_n |-> q.req.space == EMAP_SP_IO && q.pins.boot_space_select_n)
      else $error("io select with wrong space");

   a_flag_lanes: assert property (
      bus8 && $past(bus8) |-> q.doe[15:8] == $past(flag_oe_in))
      else $error("upper pins not following flag enables");

   c_write24_byte: cover property (q.done && q.req.write && s24 && bus8);
   c_read16_wide: cover property (q.done && !q.req.write && !s24 && !bus8);
   c_grant_hung: cover property (q.hung ##1 !q.grant);
   c_ack_wait: cover property (q.st == ST_STRB && !ack_in ##1 q.st == ST_STRB);

endmodule

// *** tb/emap_mem_model.sv ***
// Asynchronous external memory standing on the far side of the device pins.
// Assumes the bench resolves the shared data wire and feeds it back in.
`timescale 1ns/10ps
module emap_mem_model
   import emap_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic slow_in,
   input wire emap_pkg::emap_pins_s pins_in,
   input wire logic [15:0] wire_in,
   output logic [15:0] drive_out,
   output logic ack_out
);
   // ------------------------------------------------------------
   // Storage and access log
   // ------------------------------------------------------------
   logic [15:0] mem [int];
   logic [15:0] last_q = 16'h0000;
   logic [15:0] d_q = 16'h0000;
   logic [21:0] a_q = 22'h00_0000;
   logic [5:0] s_q = 6'h3f;
   logic w_q = 1'b0, act_q = 1'b0;
   logic [1:0] hold_q = 2'h0;
   logic [21:0] acc_addr_q [$];
   logic [15:0] acc_data_q [$];
   logic [5:0] acc_sel_q [$];
   wire logic rd = pins_in.pin_oe & ~pins_in.rd_n;
   wire logic strb = pins_in.pin_oe & (~pins_in.rd_n | ~pins_in.wr_n);

   // Slow memory holds acknowledge low for the first two strobe cycles
   assign ack_out = ~(slow_in & strb & (hold_q != 2'h2));

   // Drives only under the read strobe; else a changing value so stale data never passes
   always @* begin
      if (rd)
         drive_out = mem.exists(int'(pins_in.addr)) ? mem[int'(pins_in.addr)] : ~pins_in.addr[15:0];
      else
         drive_out = ~last_q;
   end

   // Latched every strobe cycle, so the last one before the strobe rises counts
   always @(posedge ref_clk_in) begin
      last_q <= drive_out;
      hold_q <= strb ? ((hold_q == 2'h2) ? hold_q : hold_q + 2'h1) : 2'h0;
      if (strb) begin
         act_q <= 1'b1;
         a_q <= pins_in.addr;
         d_q <= wire_in;
         w_q <= ~pins_in.wr_n;
         s_q <= {pins_in.bank_select_n, pins_in.boot_space_select_n, pins_in.io_space_select_n};
      end else if (act_q) begin
         act_q <= 1'b0;
         if (w_q)
            mem[int'(a_q)] = d_q;
         acc_addr_q.push_back(a_q);
         acc_data_q.push_back(d_q);
         acc_sel_q.push_back(s_q);
      end
   end
endmodule

// *** tb/emap_top_bench.sv ***
// Self-checking bench for the external memory port mapper.
// Assumes the memory model answers at the pins; expectations come from the bench.
`timescale 1ns/10ps
module emap_top_bench;
   import emap_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] reg_addr_in = 4'h0;
   logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, data_in, data_out, data_oe_out, mdl_drive, rv;
   logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, req_valid_in = 1'b0, busy_out, done_out, ack_in;
   logic bus_request_in = 1'b0, bus_grant_out, grant_hung_out, slow_in = 1'b0;
   logic [7:0] flag_dout_in = 8'h00, flag_oe_in = 8'h00, flag_ext = 8'h00, upper_flag_pins_out, prev_hi;
   logic [7:0] cfg = 8'h01;
   logic [23:0] rdata_out, la, wd;
   emap_req_s req_in = '0;
   emap_pins_s pins_out, prev_pins;
   int seed = 27082, failures = 0, checks_done = 0, lat0, lat1;

   emap_top emap_top_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .req_valid_in(req_valid_in), .req_in(req_in), .busy_out(busy_out), .done_out(done_out),
      .rdata_out(rdata_out), .pins_out(pins_out), .data_in(data_in), .data_out(data_out),
      .data_oe_out(data_oe_out), .ack_in(ack_in), .bus_request_in(bus_request_in),
      .bus_grant_out(bus_grant_out), .grant_hung_out(grant_hung_out), .flag_dout_in(flag_dout_in),
      .flag_oe_in(flag_oe_in), .upper_flag_pins_out(upper_flag_pins_out));
   emap_mem_model emap_mem_model_inst (.ref_clk_in(ref_clk_in), .slow_in(slow_in), .pins_in(pins_out),
      .wire_in(data_in), .drive_out(mdl_drive), .ack_out(ack_in));

   // Wire level: device lanes win where enabled; upper lanes are flag pins on a byte bus
   assign data_in = (data_oe_out & data_out) |
                    (~data_oe_out & (cfg[0] ? mdl_drive : {flag_ext, mdl_drive[7:0]}));

   always #10 ref_clk_in = ~ref_clk_in;

   // ------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      if (failures == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      @(posedge ref_clk_in);
      d = reg_rdata_out;
   endtask

   // One word request, offered for one cycle, then a bounded wait for completion
   task automatic run_word(input logic wr, x24, bl, sl, input logic [1:0] sp, input logic [23:0] a, d,
                           output int lat);
      @(posedge ref_clk_in);
      slow_in <= sl;
      req_valid_in <= 1'b1;
      req_in <= '{write: wr, xfer24: x24, boot_load: bl, space: sp, addr: a, wdata: d};
      @(posedge ref_clk_in);
      req_valid_in <= 1'b0;
      lat = 0;
      while (done_out !== 1'b1 && lat < 200) begin
         @(posedge ref_clk_in);
         lat++;
      end
      if (lat >= 200)
         check("word done", 1'b0, 1'b1);
      #1;
   endtask

   // Expected part accesses of one word, compared with what the memory logged
   task automatic verify(input logic wr, x24, bl, input logic [1:0] sp, input logic [23:0] a, d);
      logic b8, s24, ff;
      logic [1:0] sh, spc;
      logic [31:0] prod;
      logic [21:0] pa, t;
      logic [15:0] w16, lane;
      logic [23:0] rexp;
      logic [3:0] bk;
      int n;
      b8 = ~cfg[0];
      s24 = cfg[1] & x24;
      ff = cfg[1] & ~x24;
      sh = s24 ? (b8 ? 2'h2 : 2'h1) : {1'b0, b8};
      spc = bl ? EMAP_SP_BOOT : sp;
      prod = {8'h00, bl ? a + EMAP_BOOT_LOAD : a} << (sh + 2'(ff));
      n = b8 ? (s24 ? 3 : 2) : (s24 ? 2 : 1);
      w16 = x24 ? d[23:8] : d[15:0];
      check("part count", 24'(emap_mem_model_inst.acc_addr_q.size()), 24'(n));
      for (int i = 0; i < n && i < emap_mem_model_inst.acc_addr_q.size(); i++) begin
         pa = prod[21:0] + 22'((b8 && s24) ? i + 1 : i);
         t = pa - EMAP_BANK0_BASE;
         bk = (spc == EMAP_SP_MEM && pa >= EMAP_BANK0_BASE) ? ~(4'h1 << t[21:20]) : 4'hf;
         check("address", emap_mem_model_inst.acc_addr_q[i], pa);
         check("selects", emap_mem_model_inst.acc_sel_q[i], {bk, spc != EMAP_SP_BOOT, spc != EMAP_SP_IO});
         if (s24)
            lane = b8 ? 16'(d >> (8 * i)) : ((i == 0) ? {d[7:0], 8'h00} : d[23:8]);
         else
            lane = (b8 && i == 1) ? (w16 >> 8) : w16;
         if (wr && b8)
            check("byte lane", emap_mem_model_inst.acc_data_q[i][7:0], lane[7:0]);
         else if (wr)
            check("half lane", emap_mem_model_inst.acc_data_q[i], lane);
      end
      rexp = s24 ? d : (x24 ? {d[23:8], 8'h00} : {8'h00, d[15:0]});
      if (!wr)
         check("read word", x24 ? rdata_out : {8'h00, rdata_out[15:0]}, rexp);
      emap_mem_model_inst.acc_addr_q.delete();
      emap_mem_model_inst.acc_data_q.delete();
      emap_mem_model_inst.acc_sel_q.delete();
   endtask

   // Write a word, then read it back; boot loading reads what a boot write placed
   task automatic word_pair(input logic x24, bl, sl, input logic [1:0] sp, input logic [23:0] a, d);
      logic [23:0] wa;
      wa = bl ? a + EMAP_BOOT_LOAD : a;
      run_word(1'b1, x24, 1'b0, sl, sp, wa, d, lat0);
      verify(1'b1, x24, 1'b0, sp, wa, d);
      run_word(1'b0, x24, bl, sl, sp, a, d, lat1);
      verify(1'b0, x24, bl, sp, a, d);
   endtask

   // ------------------------------------------------------------
   // Pin monitor: strobe order, idle selects, release while granted, flag pins
   // ------------------------------------------------------------
   always @(posedge ref_clk_in) begin
      prev_pins <= pins_out;
      prev_hi <= data_in[15:8];
      flag_ext <= 8'($random(seed));
      flag_dout_in <= 8'($random(seed));
      flag_oe_in <= 8'($random(seed));
      if (!rst_in && pins_out.pin_oe && (!pins_out.rd_n || !pins_out.wr_n)) begin
         check("addr under strobe", pins_out.addr, prev_pins.addr);
         check("select under strobe", pins_out[8:3], prev_pins[8:3]);
      end
      if (!rst_in && !busy_out && !bus_grant_out)
         check("idle pins", {pins_out.bank_select_n, pins_out[4:1]}, 8'hff);
      if (!rst_in && bus_grant_out)
         check("released pins", {pins_out.pin_oe, data_oe_out[7:0]}, 9'h000);
      if (!rst_in && busy_out && !cfg[0])
         check("flag pins", upper_flag_pins_out, prev_hi);
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (30000) @(posedge ref_clk_in);
      failures++;
      test_done();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      reg_read(EMAP_CTRL_OFS, rv);
      check("control reset", rv, {8'h00, EMAP_CTRL_RST});
      reg_read(EMAP_STAT_OFS, rv);
      check("status idle", rv, 16'h0000);
      reg_write(4'h8, 16'hffff);
      reg_read(4'h8, rv);
      check("unmapped read", rv, 16'h0000);
      for (int c = 0; c < 16; c++) begin
         cfg = {4'($random(seed) & 3), 2'(c >> 2), 2'(c)};
         reg_write(EMAP_CTRL_OFS, {8'h00, cfg});
         reg_read(EMAP_CTRL_OFS, rv);
         check("control", rv, {8'h00, cfg});
         for (int k = 0; k < 4; k++) begin
            la = $random(seed) | 17'h1_0000;
            wd = $random(seed);
            word_pair(k[0], k[1], 1'($random(seed)),
                      k[1] ? EMAP_SP_BOOT : 2'($unsigned($random(seed)) % (k[0] ? 2 : 3)), la, wd);
         end
      end
      cfg = {4'h0, EMAP_WM_ACK, 2'h1};
      reg_write(EMAP_CTRL_OFS, {8'h00, cfg});
      word_pair(1'b0, 1'b0, 1'b0, EMAP_SP_MEM, 24'h03_1234, 24'h00_5a6b);
      lat0 = lat1;
      run_word(1'b0, 1'b0, 1'b0, 1'b1, EMAP_SP_MEM, 24'h03_1234, 24'h00_5a6b, lat1);
      verify(1'b0, 1'b0, 1'b0, EMAP_SP_MEM, 24'h03_1234, 24'h00_5a6b);
      check("ack stretch", lat1 > lat0, 1'b1);
      @(posedge ref_clk_in);
      bus_request_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      check("grant", bus_grant_out, 1'b1);
      fork
         run_word(1'b0, 1'b0, 1'b0, 1'b0, EMAP_SP_MEM, 24'h03_1234, 24'h00_5a6b, lat1);
         begin
            repeat (6) @(posedge ref_clk_in);
            check("hung", grant_hung_out, 1'b1);
            bus_request_in <= 1'b0;
         end
      join
      verify(1'b0, 1'b0, 1'b0, EMAP_SP_MEM, 24'h03_1234, 24'h00_5a6b);
      check("released", {bus_grant_out, grant_hung_out}, 2'h0);
      test_done();
   end
endmodule
